/* bench/ocr_pair_ctl_props.sv */
`timescale 1ns/1ps
module ocr_pair_ctl_props (
    // Clock and register port
    input wire core_clk,
    input wire rst,
    input wire ce,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Watched controls
    input wire ch2_src_second,
    input wire ch3_src_second,
    input wire [1:0] ch2_format,
    input wire [1:0] ch3_format,
    input wire ch2_drv_en,
    input wire [4:0] ch2_tail_ma,
    input wire [7:0] ch3_load_ohm,
    input wire ch2_p_oe,
    input wire ch2_n_oe
);
    // Write data two edges back, to match the decode latency
    reg [7:0] wd1_q;
    reg [7:0] wd2_q;
    always @(posedge core_clk) begin
        wd1_q <= reg_wdata;
        wd2_q <= wd1_q;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_src_pair: assert property (
        (ce && reg_wr && reg_addr == 8'h22) ##1 ce |-> ##1 (ch2_src_second == wd2_q[7] && ch3_src_second == wd2_q[7]))
        else $error("source select mismatch");
    chk_fmt_three: assert property (
        (ce && reg_wr && reg_addr == 8'h23) ##1 ce |-> ##1 (ch3_format == wd2_q[6:5]))
        else $error("channel three format mismatch");
    chk_drv_en: assert property (ch2_drv_en == (ch2_format != 2'h0))
        else $error("driver enable disagrees with format");
    chk_tail_off: assert property (
        (ch2_format == 2'h0 || ch2_format == 2'h3) |-> ch2_tail_ma == 5'h00)
        else $error("tail current outside differential format");
    chk_load_hcsl: assert property (ch3_format != 2'h2 |-> ch3_load_ohm == 8'h00)
        else $error("load outside HCSL format");
    chk_pin_cmos: assert property (ch2_format != 2'h3 |-> !ch2_p_oe && !ch2_n_oe)
        else $error("pin enabled outside single-ended format");
    chk_rsv_read: assert property (
        ce && reg_rd && reg_addr == 8'h23 |=> reg_rdata[7] == 1'b0 && reg_rdata[0] == 1'b0)
        else $error("reserved bit read as one");
    chk_unmapped_read: assert property (
        ce && reg_rd && reg_addr != 8'h22 && reg_addr != 8'h23 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // ocr_pair_ctl_props

/* bench/test_output_pair_control_regs.sv */
`timescale 1ns/1ps
module test_output_pair_control_regs;
    // ----
    // Signals
    // ----
    logic core_clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, rd_seen = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, v2, v3, ua;
    logic [31:0] seed = 32'h81fe242c, r;
    logic [7:0] exp_q[$];
    int n_mismatch = 0, tests_run = 0;
    wire [7:0] reg_rdata, l2, l3;
    wire [4:0] t2, t3;
    wire [1:0] f2, f3;
    wire s2, e2, po2, pr2, pi2, no2, nr2, ni2, s3, e3, po3, pr3, pi3, no3, nr3, ni3;

    ocr_pair_ctl uut (.core_clk(core_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch2_src_second(s2), .ch2_format(f2),
        .ch2_drv_en(e2), .ch2_tail_ma(t2), .ch2_load_ohm(l2), .ch2_p_oe(po2), .ch2_p_run(pr2), .ch2_p_inv(pi2),
        .ch2_n_oe(no2), .ch2_n_run(nr2), .ch2_n_inv(ni2), .ch3_src_second(s3), .ch3_format(f3),
        .ch3_drv_en(e3), .ch3_tail_ma(t3), .ch3_load_ohm(l3), .ch3_p_oe(po3), .ch3_p_run(pr3), .ch3_p_inv(pi3),
        .ch3_n_oe(no3), .ch3_n_run(nr3), .ch3_n_inv(ni3));

    initial forever #25 core_clk = ~core_clk;

    // ----
    // Helpers
    // ----
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function logic [2:0] pin(input logic c, input logic [1:0] k);
        return c ? {|k, k[1], k == 2'h2} : 3'h0;
    endfunction

    // Expected {enable, tail, load, p pin, n pin} of one channel
    function logic [19:0] dec(input logic [1:0] f, input logic [1:0] a, input logic [1:0] b);
        logic [4:0] t;
        logic [7:0] l;
        t = (f == 2'h1 || f == 2'h2) ? (a == 2'h3 ? (f == 2'h2 ? 5'h10 : 5'h08) : 5'h04 + {2'h0, a, 1'b0}) : 5'h00;
        l = (f == 2'h2 && b != 2'h0) ? 8'h19 << b : 8'h00;
        return {f != 2'h0, t, l, pin(f == 2'h3, a), pin(f == 2'h3, b)};
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Each task raises one strobe and drops the other; idle drops both, so no signal is set twice per step
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge core_clk);
    endtask

    task idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask

    task chk_dec(input logic [7:0] a, input logic [7:0] b);
        @(negedge core_clk);
        check({s2, s3, f2, f3}, {a[7], a[7], a[6:5], b[6:5]}, "source and format");
        check({e2, t2, l2, po2, pr2, pi2, no2, nr2, ni2}, dec(a[6:5], a[4:3], a[2:1]), "ch2");
        check({e3, t3, l3, po3, pr3, pi3, no3, nr3, ni3}, dec(b[6:5], b[4:3], b[2:1]), "ch3");
        @(posedge core_clk);
    endtask

    task print_verdict();
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Read data stand in the cycle after the strobe
    always @(posedge core_clk) begin
        if (rd_seen) check(reg_rdata, exp_q.pop_front(), "reg_rdata");
        rd_seen <= reg_rd && ce && !rst;
    end

    // ----
    // Sequence
    // ----
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'h22, 8'hb0);
        rd(8'h23, 8'h30);
        idle(1);
        chk_dec(8'hb0, 8'h30);
        for (int i = 0; i < 64; i++) begin
            r = xs();
            v2 = {r[7], i[5:0], r[0]};
            v3 = {r[15], i[1:0], i[5:2], r[8]};
            wr(8'h22, v2);
            wr(8'h23, v3);
            rd(8'h22, v2 & 8'hfe);
            rd(8'h23, v3 & 8'h7e);
            idle(1);
            chk_dec(v2 & 8'hfe, v3 & 8'h7e);
        end
        // Unmapped access, then a write lost while the enable is low
        ua = r[23:16];
        if (ua == 8'h22 || ua == 8'h23) ua = 8'h5a;
        wr(ua, 8'hff);
        rd(ua, 8'h00);
        ce <= 1'b0;
        wr(8'h22, ~v2);
        ce <= 1'b1;
        rd(8'h22, v2 & 8'hfe);
        rd(8'h23, v3 & 8'h7e);
        idle(2);
        chk_dec(v2 & 8'hfe, v3 & 8'h7e);
        for (int k = 0; k < 10 && exp_q.size() > 0; k++) @(posedge core_clk);
        if (exp_q.size() > 0) n_mismatch++;
        print_verdict();
    end
endmodule // test_output_pair_control_regs

bind ocr_pair_ctl ocr_pair_ctl_props chk (.*);

/* src/ocr_consts.vh */
`ifndef OCR_CONSTS_VH
`define OCR_CONSTS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define OCR_ADDR_W 8
`define OCR_DATA_W 8
`define OCR_ADDR_OUT2 8'h22
`define OCR_ADDR_OUT3 8'h23

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OCR_SRC_BIT 7
`define OCR_FMT_HI 6
`define OCR_FMT_LO 5
`define OCR_MODEA_HI 4
`define OCR_MODEA_LO 3
`define OCR_MODEB_HI 2
`define OCR_MODEB_LO 1

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define OCR_SRC_RST 1'b1
`define OCR_FMT_RST 2'h1
`define OCR_MODEA_RST 2'h2
`define OCR_MODEB_RST 2'h0
`define OCR_OUT2_RST 8'hb0
`define OCR_OUT3_RST 8'h30
`define OCR_OUT2_MASK 8'hfe
`define OCR_OUT3_MASK 8'h7e
`define OCR_RDATA_IDLE 8'h00

// ----------------------------------------------------------------
// Format codes
// ----------------------------------------------------------------
`define OCR_FMT_OFF 2'h0
`define OCR_FMT_ACDIFF 2'h1
`define OCR_FMT_HCSL 2'h2
`define OCR_FMT_CMOS 2'h3

// ----------------------------------------------------------------
// Mode codes and analog values
// ----------------------------------------------------------------
`define OCR_MODE_0 2'h0
`define OCR_MODE_1 2'h1
`define OCR_MODE_2 2'h2
`define OCR_MODE_3 2'h3
`define OCR_TAIL_4MA 5'h04
`define OCR_TAIL_6MA 5'h06
`define OCR_TAIL_8MA 5'h08
`define OCR_TAIL_16MA 5'h10
`define OCR_TAIL_NONE 5'h00
`define OCR_LOAD_NONE 8'h00
`define OCR_LOAD_50 8'h32
`define OCR_LOAD_100 8'h64
`define OCR_LOAD_200 8'hc8

`endif

/* src/ocr_ctl_reg.v */
`timescale 1ns/1ps
`include "ocr_consts.vh"

module ocr_ctl_reg #(
    parameter [7:0] RST_VAL = 8'h00,
    parameter [7:0] WR_MASK = 8'hff
) (
    // Clock and control
    input wire core_clk,
    input wire rst,
    input wire ce,
    // Write side
    input wire we,
    input wire [7:0] wdata,
    // Stored value
    output wire [7:0] q
);

    reg [7:0] val_q;
    wire [7:0] val_d;

    // Reserved bits hold their reset value, which is zero
    assign val_d = (wdata & WR_MASK) | (RST_VAL & ~WR_MASK);
    assign q = val_q;

    always @(posedge core_clk) begin
        if (rst) begin
            val_q <= RST_VAL;
        end else if (ce && we) begin
            val_q <= val_d;
        end
    end

endmodule // ocr_ctl_reg

/* src/ocr_pair_ctl.v */
`timescale 1ns/1ps
`include "ocr_consts.vh"

module ocr_pair_ctl (
    // Clock, reset, enable
    input wire core_clk,
    input wire rst,
    input wire ce,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata,
    // Channel two controls
    output wire ch2_src_second,
    output wire [1:0] ch2_format,
    output wire ch2_drv_en,
    output wire [4:0] ch2_tail_ma,
    output wire [7:0] ch2_load_ohm,
    output wire ch2_p_oe,
    output wire ch2_p_run,
    output wire ch2_p_inv,
    output wire ch2_n_oe,
    output wire ch2_n_run,
    output wire ch2_n_inv,
    // Channel three controls
    output wire ch3_src_second,
    output wire [1:0] ch3_format,
    output wire ch3_drv_en,
    output wire [4:0] ch3_tail_ma,
    output wire [7:0] ch3_load_ohm,
    output wire ch3_p_oe,
    output wire ch3_p_run,
    output wire ch3_p_inv,
    output wire ch3_n_oe,
    output wire ch3_n_run,
    output wire ch3_n_inv
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function is_diff;
        input [1:0] fmt;
        begin
            is_diff = (fmt == `OCR_FMT_ACDIFF) || (fmt == `OCR_FMT_HCSL);
        end
    endfunction

    // Formats other than off power the driver
    function is_on;
        input [1:0] fmt;
        begin
            is_on = (fmt != `OCR_FMT_OFF);
        end
    endfunction

    // Address decode shared by the write and read paths
    function [1:0] reg_sel;
        input [7:0] addr;
        begin
            reg_sel = 2'b00;
            case (addr)
                `OCR_ADDR_OUT2: reg_sel = 2'b01;
                `OCR_ADDR_OUT3: reg_sel = 2'b10;
                default: reg_sel = 2'b00;
            endcase
        end
    endfunction

    function [4:0] tail_of;
        input [1:0] fmt;
        input [1:0] code;
        begin
            tail_of = `OCR_TAIL_NONE;
            if (is_diff(fmt)) begin
                case (code)
                    `OCR_MODE_0: tail_of = `OCR_TAIL_4MA;
                    `OCR_MODE_1: tail_of = `OCR_TAIL_6MA;
                    `OCR_MODE_2: tail_of = `OCR_TAIL_8MA;
                    `OCR_MODE_3: tail_of = (fmt == `OCR_FMT_HCSL) ? `OCR_TAIL_16MA : `OCR_TAIL_8MA;
                    default: tail_of = `OCR_TAIL_NONE;
                endcase
            end
        end
    endfunction

    function [7:0] load_of;
        input [1:0] fmt;
        input [1:0] code;
        begin
            load_of = `OCR_LOAD_NONE;
            if (fmt == `OCR_FMT_HCSL) begin
                case (code)
                    `OCR_MODE_0: load_of = `OCR_LOAD_NONE;
                    `OCR_MODE_1: load_of = `OCR_LOAD_50;
                    `OCR_MODE_2: load_of = `OCR_LOAD_100;
                    `OCR_MODE_3: load_of = `OCR_LOAD_200;
                    default: load_of = `OCR_LOAD_NONE;
                endcase
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    wire wr_out2;
    wire wr_out3;
    wire [7:0] out2_q;
    wire [7:0] out3_q;
    wire [1:0] addr_hit;

    // Exact match only; no aliases of the two offsets
    assign addr_hit = reg_sel(reg_addr);

    assign wr_out2 = reg_wr && addr_hit[0];
    assign wr_out3 = reg_wr && addr_hit[1];

    // Bit 0 is masked off and stays zero
    ocr_ctl_reg #(
        .RST_VAL(`OCR_OUT2_RST),
        .WR_MASK(`OCR_OUT2_MASK)
    ) u_out2 (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .we(wr_out2),
        .wdata(reg_wdata),
        .q(out2_q)
    );

    // Bits 7 and 0 are masked off and stay zero
    ocr_ctl_reg #(
        .RST_VAL(`OCR_OUT3_RST),
        .WR_MASK(`OCR_OUT3_MASK)
    ) u_out3 (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .we(wr_out3),
        .wdata(reg_wdata),
        .q(out3_q)
    );

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    reg [7:0] rdata_q;
    reg [7:0] rdata_d;

    // Unmapped reads return zero so software can probe the map safely
    always @* begin
        rdata_d = `OCR_RDATA_IDLE;
        if (reg_rd) begin
            case (addr_hit)
                2'b01: rdata_d = out2_q;
                2'b10: rdata_d = out3_q;
                default: rdata_d = `OCR_RDATA_IDLE;
            endcase
        end
    end

    // Data stand for one enabled cycle, zero otherwise; held while ce is low
    always @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= `OCR_RDATA_IDLE;
        end else if (ce) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ----------------------------------------------------------------
    // Per-channel decode and output flops
    // ----------------------------------------------------------------
    wire [15:0] regs_w;
    wire src_second_w;

    assign regs_w = {out3_q, out2_q};
    // One selector feeds both channels of the pair
    assign src_second_w = out2_q[`OCR_SRC_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
            wire [7:0] r;
            wire [1:0] fmt;
            wire [1:0] mode_a;
            wire [1:0] mode_b;
            wire single_end;
            wire drv_on;
            wire p_oe_d;
            wire p_run_d;
            wire p_inv_d;
            wire n_oe_d;
            wire n_run_d;
            wire n_inv_d;
            reg src_q;
            reg [1:0] fmt_q;
            reg en_q;
            reg [4:0] tail_q;
            reg [7:0] load_q;
            reg p_oe_q;
            reg p_run_q;
            reg p_inv_q;
            reg n_oe_q;
            reg n_run_q;
            reg n_inv_q;

            assign r = regs_w[gi*8 +: 8];
            assign fmt = r[`OCR_FMT_HI:`OCR_FMT_LO];
            assign mode_a = r[`OCR_MODEA_HI:`OCR_MODEA_LO];
            assign mode_b = r[`OCR_MODEB_HI:`OCR_MODEB_LO];
            assign single_end = (fmt == `OCR_FMT_CMOS);
            assign drv_on = is_on(fmt);

            // Both pins use one decoder type; only the code differs
            ocr_pin_dec u_pdec (
                .se_mode(single_end),
                .code(mode_a),
                .oe(p_oe_d),
                .run(p_run_d),
                .inv(p_inv_d)
            );

            ocr_pin_dec u_ndec (
                .se_mode(single_end),
                .code(mode_b),
                .oe(n_oe_d),
                .run(n_run_d),
                .inv(n_inv_d)
            );

            // Registered so the analog stage never sees decode glitches
            always @(posedge core_clk) begin
                if (rst) begin
                    src_q <= `OCR_SRC_RST;
                    fmt_q <= `OCR_FMT_RST;
                    en_q <= 1'b1;
                    tail_q <= `OCR_TAIL_8MA;
                    load_q <= `OCR_LOAD_NONE;
                    p_oe_q <= 1'b0;
                    p_run_q <= 1'b0;
                    p_inv_q <= 1'b0;
                    n_oe_q <= 1'b0;
                    n_run_q <= 1'b0;
                    n_inv_q <= 1'b0;
                end else if (ce) begin
                    src_q <= src_second_w;
                    fmt_q <= fmt;
                    en_q <= drv_on;
                    tail_q <= tail_of(fmt, mode_a);
                    load_q <= load_of(fmt, mode_b);
                    p_oe_q <= p_oe_d;
                    p_run_q <= p_run_d;
                    p_inv_q <= p_inv_d;
                    n_oe_q <= n_oe_d;
                    n_run_q <= n_run_d;
                    n_inv_q <= n_inv_d;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Output wiring
    // ----------------------------------------------------------------
    assign ch2_src_second = g_ch[0].src_q;
    assign ch2_format = g_ch[0].fmt_q;
    assign ch2_drv_en = g_ch[0].en_q;
    assign ch2_tail_ma = g_ch[0].tail_q;
    assign ch2_load_ohm = g_ch[0].load_q;
    assign ch2_p_oe = g_ch[0].p_oe_q;
    assign ch2_p_run = g_ch[0].p_run_q;
    assign ch2_p_inv = g_ch[0].p_inv_q;
    assign ch2_n_oe = g_ch[0].n_oe_q;
    assign ch2_n_run = g_ch[0].n_run_q;
    assign ch2_n_inv = g_ch[0].n_inv_q;

    // Channel three follows the shared selector
    assign ch3_src_second = g_ch[1].src_q;
    assign ch3_format = g_ch[1].fmt_q;
    assign ch3_drv_en = g_ch[1].en_q;
    assign ch3_tail_ma = g_ch[1].tail_q;
    assign ch3_load_ohm = g_ch[1].load_q;
    assign ch3_p_oe = g_ch[1].p_oe_q;
    assign ch3_p_run = g_ch[1].p_run_q;
    assign ch3_p_inv = g_ch[1].p_inv_q;
    assign ch3_n_oe = g_ch[1].n_oe_q;
    assign ch3_n_run = g_ch[1].n_run_q;
    assign ch3_n_inv = g_ch[1].n_inv_q;

endmodule // ocr_pair_ctl

/* src/ocr_pin_dec.v */
`timescale 1ns/1ps
`include "ocr_consts.vh"

module ocr_pin_dec (
    // Inputs
    input wire se_mode,
    input wire [1:0] code,
    // Pin controls
    output reg oe,
    output reg run,
    output reg inv
);

    always @* begin
        oe = 1'b0;
        run = 1'b0;
        inv = 1'b0;
        if (se_mode) begin
            case (code)
                `OCR_MODE_0: begin
                    oe = 1'b0;
                end
                `OCR_MODE_1: begin
                    oe = 1'b1;
                end
                `OCR_MODE_2: begin
                    oe = 1'b1;
                    run = 1'b1;
                    inv = 1'b1;
                end
                default: begin
                    oe = 1'b1;
                    run = 1'b1;
                end
            endcase
        end
    end

endmodule // ocr_pin_dec
